// ### common/csg_pkg.sv
// Constants, register map and field layout of the clock/status/pin slice.
// Assumes one 40 MHz register clock; all other clocks arrive as pins.
//
// Behaviour
// - A write to the measure register starts a pixel edge count.
// - The interval lasts the written value times the oscillator period.
// - Reading the measure register returns the last interval's pixel count.
// - The pixel count saturates and holds at 0xff.
// - Status bit 4 shows dual-link mode, 0 for single-link.
// - Status bit 3 shows audio PLL lock.
// - Status bit 0 shows clock recovery lock.
// - In dual-link mode the lock bit needs both channels locked.
// - Local level drives the pin only when enabled, output and not remote.
// - Remote drive makes the pin an output carrying the remote value.
// - {dir,en}: 00 functional, 10 high-z, 01 GP output, 11 GP input.
// - With second port selected, pin 0 setup controls port two pin 0.
// - Register 0x1e sets pins 1 and 2, pin 2 level at bit 7.
// - Pin 2 remote, dir, enable at bits 6..4; pin 1 like pin 0.

package csg_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] PIXEL_CLOCK_MEASURE = 8'h1b;
    localparam logic [7:0] LINK_GENERAL_STATUS = 8'h1c;
    localparam logic [7:0] PIN0_SETUP = 8'h1d;
    localparam logic [7:0] PIN1_PIN2_SETUP = 8'h1e;
    localparam logic [7:0] IRQ_STATUS = 8'h30;
    localparam logic [7:0] IRQ_ENABLE = 8'h31;
    localparam logic [7:0] IRQ_CLEAR = 8'h32;
    localparam logic [7:0] PORT_CONTROL = 8'h33;
    localparam logic [7:0] PIN_LEVELS = 8'h34;

    // ----------------------------------------------------------------
    // Field positions and values
    // ----------------------------------------------------------------
    localparam int STS_LOCK_BIT = 0;
    localparam int STS_AUDIO_BIT = 3;
    localparam int STS_DUAL_BIT = 4;
    localparam int NIB_EN = 0;
    localparam int NIB_DIR = 1;
    localparam int NIB_REMOTE = 2;
    localparam int NIB_LEVEL = 3;
    localparam int PIN2_LSB = 4;
    localparam int REV_LSB = 4;
    localparam int IRQ_MEAS = 0;
    localparam int IRQ_LOCK = 1;
    localparam int IRQ_AUDIO = 2;
    localparam int IRQ_W = 3;
    localparam logic [1:0] MODE_FUNC = 2'h0;
    localparam logic [1:0] MODE_HIZ = 2'h2;
    localparam logic [1:0] MODE_GP_OUT = 2'h1;
    localparam logic [1:0] MODE_GP_IN = 2'h3;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hff;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int OSC_PERIOD_NS = 40;
    localparam int SYS_PERIOD_NS = 25;
    // Oscillator is sampled, so it must stay slower than half the clock
    localparam int OSC_MIN_CYC =
        (OSC_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

    typedef enum logic {MEAS_IDLE, MEAS_RUN} csg_meas_type;

endpackage : csg_pkg

// ### design/csg_pix_meter.sv
// Pixel clock meter: counts pixel edges over a number of oscillator periods.
// Both clocks are pins sampled by the register clock through two flops.

`timescale 1ns/100ps
`default_nettype none

module csg_pix_meter #(
    parameter int CW = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Sampled clocks
    input wire logic pix_clk_i,
    input wire logic osc_clk_i,
    // Control
    input wire logic start_i,
    input wire logic [CW-1:0] span_i,
    // Result
    output logic busy_o,
    output logic done_o,
    output logic [CW-1:0] count_o
);

    // ----------------------------------------------------------------
    // Synchronisers and edge detect
    // ----------------------------------------------------------------
    logic [2:0] pix_q;
    logic [2:0] osc_q;
    logic pix_rise;
    logic osc_rise;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pix_q <= 3'h0;
            osc_q <= 3'h0;
        end else begin
            pix_q <= {pix_q[1:0], pix_clk_i};
            osc_q <= {osc_q[1:0], osc_clk_i};
        end
    end

    assign pix_rise = pix_q[1] & ~pix_q[2];
    assign osc_rise = osc_q[1] & ~osc_q[2];

    // ----------------------------------------------------------------
    // Interval state machine
    // ----------------------------------------------------------------
    csg_pkg::csg_meas_type state_q, state_d;
    logic [CW-1:0] left_q, left_d;
    logic [CW-1:0] count_q, count_d;
    logic done_q, done_d;
    logic sat;

    assign sat = (count_q == csg_pkg::COUNT_MAX[CW-1:0]);

    always_comb begin
        state_d = state_q;
        left_d = left_q;
        count_d = count_q;
        done_d = 1'b0;
        if (start_i) begin
            count_d = '0;
            left_d = span_i;
            if (span_i == '0) begin
                done_d = 1'b1;
                state_d = csg_pkg::MEAS_IDLE;
            end else begin
                state_d = csg_pkg::MEAS_RUN;
            end
        end else begin
            case (state_q)
                csg_pkg::MEAS_IDLE: begin
                    state_d = csg_pkg::MEAS_IDLE;
                end
                csg_pkg::MEAS_RUN: begin
                    if (pix_rise && !sat) begin
                        count_d = count_q + 1'b1;
                    end
                    if (osc_rise) begin
                        left_d = left_q - 1'b1;
                        if (left_q == {{(CW-1){1'b0}}, 1'b1}) begin
                            done_d = 1'b1;
                            state_d = csg_pkg::MEAS_IDLE;
                        end
                    end
                end
                default: begin
                    state_d = csg_pkg::MEAS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= csg_pkg::MEAS_IDLE;
            left_q <= '0;
            count_q <= '0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            left_q <= left_d;
            count_q <= count_d;
            done_q <= done_d;
        end
    end

    assign busy_o = (state_q == csg_pkg::MEAS_RUN);
    assign done_o = done_q;
    assign count_o = count_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    count_sat_a:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sat && !start_i |=> sat)
        else $error("pixel count left saturation");

    count_clear_a:
    assert property (@(posedge clk_i) disable iff (!rst_n_i)
        start_i |=> count_q == '0)
        else $error("pixel count not cleared on start");

endmodule // csg_pix_meter

`default_nettype wire

// ### design/csg_regs.sv
// Register slice: pixel clock meter, link status, pin setup, interrupts.
// Assumes a same-clock register port master; status and clocks are pins.
//
// The implementer's own choice: the strobed register port.

`timescale 1ns/100ps
`default_nettype none

module csg_regs #(
    parameter int NPORT = 2,
    parameter int NPIN = 3,
    // Arbitrary revision value
    parameter logic [3:0] REVISION_FIELD = 4'h1
) (
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RSTN_I,
    // Register port
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    // Measured clocks
    input wire logic PIX_CLK_I,
    input wire logic OSC_CLK_I,
    // Link status pins
    input wire logic DUAL_LINK_I,
    input wire logic AUDIO_LOCK_I,
    input wire logic [1:0] CDR_LOCK_I,
    // Pin sources
    input wire logic [NPORT*NPIN-1:0] FUNC_OUT_I,
    input wire logic [NPORT*NPIN-1:0] REMOTE_LEVEL_I,
    // Pins
    input wire logic [NPORT*NPIN-1:0] PIN_IN_I,
    output logic [NPORT*NPIN-1:0] PIN_OUT_O,
    output logic [NPORT*NPIN-1:0] PIN_OE_O,
    // Interrupt
    output logic IRQ_O
);

    localparam int NP = NPORT * NPIN;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [3:0] sts_s1_q;
    logic [3:0] sts_s2_q;
    logic [NP-1:0] pin_s1_q;
    logic [NP-1:0] pin_s2_q;

    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            sts_s1_q <= 4'h0;
            sts_s2_q <= 4'h0;
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            sts_s1_q <= {DUAL_LINK_I, AUDIO_LOCK_I, CDR_LOCK_I};
            sts_s2_q <= sts_s1_q;
            pin_s1_q <= PIN_IN_I;
            pin_s2_q <= pin_s1_q;
        end
    end

    logic dual_link;
    logic audio_lock;
    logic link_lock;

    assign dual_link = sts_s2_q[3];
    assign audio_lock = sts_s2_q[2];
    // Dual link needs both channels, single link only the first
    assign link_lock = dual_link ? &sts_s2_q[1:0] : sts_s2_q[0];

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    logic wr_meas;
    logic wr_pin0;
    logic wr_pin12;
    logic wr_ien;
    logic wr_iclr;
    logic wr_port;

    assign wr_meas = WR_I && (ADDR_I == csg_pkg::PIXEL_CLOCK_MEASURE);
    assign wr_pin0 = WR_I && (ADDR_I == csg_pkg::PIN0_SETUP);
    assign wr_pin12 = WR_I && (ADDR_I == csg_pkg::PIN1_PIN2_SETUP);
    assign wr_ien = WR_I && (ADDR_I == csg_pkg::IRQ_ENABLE);
    assign wr_iclr = WR_I && (ADDR_I == csg_pkg::IRQ_CLEAR);
    assign wr_port = WR_I && (ADDR_I == csg_pkg::PORT_CONTROL);

    // ----------------------------------------------------------------
    // Pixel clock meter
    // ----------------------------------------------------------------
    logic meas_busy;
    logic meas_done;
    logic [7:0] meas_count;

    csg_pix_meter #(
        .CW(8)
    ) u_meter (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RSTN_I),
        .pix_clk_i(PIX_CLK_I),
        .osc_clk_i(OSC_CLK_I),
        .start_i(wr_meas),
        .span_i(WDATA_I),
        .busy_o(meas_busy),
        .done_o(meas_done),
        .count_o(meas_count)
    );

    // ----------------------------------------------------------------
    // Setup registers, one copy per port
    // ----------------------------------------------------------------
    logic port_sel_q, port_sel_d;
    logic [3:0] cfg0_q [NPORT];
    logic [3:0] cfg0_d [NPORT];
    logic [7:0] cfg12_q [NPORT];
    logic [7:0] cfg12_d [NPORT];

    always_comb begin
        port_sel_d = port_sel_q;
        cfg0_d = cfg0_q;
        cfg12_d = cfg12_q;
        if (wr_port) begin
            port_sel_d = WDATA_I[0];
        end
        // Writes land in the copy of the selected port only
        if (wr_pin0) begin
            cfg0_d[port_sel_q] = WDATA_I[3:0];
        end
        if (wr_pin12) begin
            cfg12_d[port_sel_q] = WDATA_I;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            port_sel_q <= 1'b0;
            for (int p = 0; p < NPORT; p++) begin
                cfg0_q[p] <= csg_pkg::RESET_BYTE[3:0];
                cfg12_q[p] <= csg_pkg::RESET_BYTE;
            end
        end else begin
            port_sel_q <= port_sel_d;
            cfg0_q <= cfg0_d;
            cfg12_q <= cfg12_d;
        end
    end

    // ----------------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------------
    logic [NP-1:0] pin_out_d;
    logic [NP-1:0] pin_oe_d;
    logic [NP-1:0] pin_out_q;
    logic [NP-1:0] pin_oe_q;

    genvar gp;
    generate
        for (gp = 0; gp < NP; gp++) begin : g_pin
            localparam int PORT = gp / NPIN;
            localparam int IDX = gp % NPIN;
            logic [3:0] nib;
            logic [1:0] mode;
            if (IDX == 0) begin : g_p0
                assign nib = cfg0_q[PORT];
            end else if (IDX == 1) begin : g_p1
                assign nib = cfg12_q[PORT][3:0];
            end else begin : g_p2
                assign nib = cfg12_q[PORT][csg_pkg::PIN2_LSB+:4];
            end
            assign mode = {nib[csg_pkg::NIB_DIR], nib[csg_pkg::NIB_EN]};
            always_comb begin
                pin_out_d[gp] = 1'b0;
                pin_oe_d[gp] = 1'b0;
                if (nib[csg_pkg::NIB_REMOTE]) begin
                    // Remote drive wins over every local mode
                    pin_out_d[gp] = REMOTE_LEVEL_I[gp];
                    pin_oe_d[gp] = 1'b1;
                end else begin
                    case (mode)
                        csg_pkg::MODE_FUNC: begin
                            pin_out_d[gp] = FUNC_OUT_I[gp];
                            pin_oe_d[gp] = 1'b1;
                        end
                        csg_pkg::MODE_GP_OUT: begin
                            pin_out_d[gp] = nib[csg_pkg::NIB_LEVEL];
                            pin_oe_d[gp] = 1'b1;
                        end
                        csg_pkg::MODE_HIZ: begin
                            pin_oe_d[gp] = 1'b0;
                        end
                        csg_pkg::MODE_GP_IN: begin
                            pin_oe_d[gp] = 1'b0;
                        end
                        default: begin
                            pin_oe_d[gp] = 1'b0;
                        end
                    endcase
                end
            end
        end
    endgenerate

    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pin_out_q <= '0;
            pin_oe_q <= '0;
        end else begin
            pin_out_q <= pin_out_d;
            pin_oe_q <= pin_oe_d;
        end
    end

    assign PIN_OUT_O = pin_out_q;
    assign PIN_OE_O = pin_oe_q;

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    logic [csg_pkg::IRQ_W-1:0] irq_sts_q, irq_sts_d;
    logic [csg_pkg::IRQ_W-1:0] irq_en_q, irq_en_d;
    logic [csg_pkg::IRQ_W-1:0] irq_evt;
    logic lock_q;
    logic audio_q;

    assign irq_evt[csg_pkg::IRQ_MEAS] = meas_done;
    assign irq_evt[csg_pkg::IRQ_LOCK] = link_lock ^ lock_q;
    assign irq_evt[csg_pkg::IRQ_AUDIO] = audio_lock ^ audio_q;

    always_comb begin
        irq_en_d = irq_en_q;
        irq_sts_d = irq_sts_q;
        if (wr_ien) begin
            irq_en_d = WDATA_I[csg_pkg::IRQ_W-1:0];
        end
        if (wr_iclr) begin
            irq_sts_d = irq_sts_d & ~WDATA_I[csg_pkg::IRQ_W-1:0];
        end
        // A new event beats a clear in the same cycle
        irq_sts_d = irq_sts_d | irq_evt;
    end

    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            irq_sts_q <= '0;
            irq_en_q <= '0;
            lock_q <= 1'b0;
            audio_q <= 1'b0;
        end else begin
            irq_sts_q <= irq_sts_d;
            irq_en_q <= irq_en_d;
            lock_q <= link_lock;
            audio_q <= audio_lock;
        end
    end

    assign IRQ_O = |(irq_sts_q & irq_en_q);

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] status_byte;

    always_comb begin
        status_byte = csg_pkg::RESET_BYTE;
        status_byte[csg_pkg::STS_DUAL_BIT] = dual_link;
        status_byte[csg_pkg::STS_AUDIO_BIT] = audio_lock;
        status_byte[csg_pkg::STS_LOCK_BIT] = link_lock;
    end

    always_comb begin
        rdata_d = csg_pkg::RESET_BYTE;
        if (RD_I) begin
            case (ADDR_I)
                csg_pkg::PIXEL_CLOCK_MEASURE: rdata_d = meas_count;
                csg_pkg::LINK_GENERAL_STATUS: rdata_d = status_byte;
                csg_pkg::PIN0_SETUP:
                    rdata_d = {REVISION_FIELD, cfg0_q[port_sel_q]};
                csg_pkg::PIN1_PIN2_SETUP: rdata_d = cfg12_q[port_sel_q];
                csg_pkg::IRQ_STATUS: rdata_d = 8'(irq_sts_q);
                csg_pkg::IRQ_ENABLE: rdata_d = 8'(irq_en_q);
                csg_pkg::PORT_CONTROL: rdata_d = {meas_busy, 6'h00,
                                                  port_sel_q};
                csg_pkg::PIN_LEVELS: rdata_d = 8'(pin_s2_q);
                default: rdata_d = csg_pkg::RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rdata_q <= csg_pkg::RESET_BYTE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign RDATA_O = rdata_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RSTN_I);

    meas_read_a:
    assert property (RD_I && ADDR_I == csg_pkg::PIXEL_CLOCK_MEASURE
        |=> RDATA_O == $past(meas_count))
        else $error("measure read mismatch");

    meas_start_a:
    assert property (wr_meas && WDATA_I != 8'h00 |=> meas_busy)
        else $error("measure did not start");

    meas_span_a:
    assert property (meas_busy && u_meter.osc_rise && u_meter.left_q == 8'h01
        && !wr_meas |=> meas_done && !meas_busy)
        else $error("interval did not end on its last period");

    dual_bit_a:
    assert property (RD_I && ADDR_I == csg_pkg::LINK_GENERAL_STATUS
        |=> RDATA_O[csg_pkg::STS_DUAL_BIT] == $past(sts_s2_q[3]))
        else $error("dual link bit wrong");

    audio_bit_a:
    assert property (RD_I && ADDR_I == csg_pkg::LINK_GENERAL_STATUS
        |=> RDATA_O[csg_pkg::STS_AUDIO_BIT] == $past(sts_s2_q[2]))
        else $error("audio lock bit wrong");

    dual_lock_a:
    assert property (dual_link && !(&sts_s2_q[1:0]) |-> !link_lock)
        else $error("lock shown with one channel down");

    single_lock_a:
    assert property (!dual_link |-> link_lock == sts_s2_q[0])
        else $error("single link lock wrong");

    remote_pin_a:
    assert property (cfg12_q[0][csg_pkg::NIB_REMOTE]
        |=> PIN_OE_O[1] && PIN_OUT_O[1] == $past(REMOTE_LEVEL_I[1]))
        else $error("remote drive not on pin");

    local_pin_a:
    assert property (cfg0_q[0] == 4'h9 |=> PIN_OE_O[0] && PIN_OUT_O[0])
        else $error("local level not driven");

    hiz_pin_a:
    assert property (cfg0_q[1][2:0] == 3'h2 |=> !PIN_OE_O[NPIN])
        else $error("high impedance pin driven");

    port_sel_a:
    assert property (port_sel_q && wr_pin0 |=> cfg0_q[0] == $past(cfg0_q[0]))
        else $error("port one setup changed while port two selected");

    pin2_level_a:
    assert property (cfg12_q[0][7:4] == 4'h9 |=> PIN_OE_O[2] && PIN_OUT_O[2])
        else $error("pin 2 level bit not driven");

    irq_set_a:
    assert property (|irq_evt |=> |irq_sts_q)
        else $error("event lost");

    meas_cov: cover property (wr_meas ##[1:40] meas_done);
    sat_cov: cover property (meas_busy && meas_count == csg_pkg::COUNT_MAX);
    port_cov: cover property (port_sel_q && wr_pin12);
    irq_cov: cover property ($rose(IRQ_O));

endmodule // csg_regs

`default_nettype wire

// ### verif/csg_regs_bench.sv
// Self-checking bench for the clock, status and pin register slice.
// Assumes reads answer one cycle after the strobe; drives every port.

`timescale 1ns/100ps
`default_nettype none

module csg_regs_bench;

    // ----------------------------------------------------------------
    // Stimulus and bookkeeping
    // ----------------------------------------------------------------
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_d = 1'b0;
    logic pclk = 1'b0;
    logic oclk = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic dual = 1'b0;
    logic aud = 1'b0;
    logic [1:0] cdr = 2'h0;
    logic [5:0] fout = 6'h00;
    logic [5:0] rlev = 6'h00;
    logic [5:0] pin_in = 6'h00;
    wire logic [7:0] rdata;
    wire logic [5:0] pout;
    wire logic [5:0] poe;
    wire logic irq;
    int n_errors = 0;
    int compares = 0;
    int pix_half = 150;
    logic [31:0] seed = 32'he70e7d6e;
    logic [15:0] expq[$];
    logic [3:0] cfg0[2] = '{4'h0, 4'h0};
    logic [7:0] cfg12[2] = '{8'h00, 8'h00};
    logic psel = 1'b0;
    localparam logic [3:0] REV = 4'h1;

    // Oscillator kept slower than the nominal rate: the design samples it
    initial begin
        forever #12.5 clk = ~clk;
    end
    initial begin
        forever #50 oclk = ~oclk;
    end
    initial begin
        forever #(pix_half) pclk = ~pclk;
    end

    csg_regs u_csg_regs (
        .SYS_CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .PIX_CLK_I(pclk),
        .OSC_CLK_I(oclk), .DUAL_LINK_I(dual), .AUDIO_LOCK_I(aud),
        .CDR_LOCK_I(cdr), .FUNC_OUT_I(fout), .REMOTE_LEVEL_I(rlev),
        .PIN_IN_I(pin_in), .PIN_OUT_O(pout), .PIN_OE_O(poe), .IRQ_O(irq)
    );

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic test_done;
        if (n_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Expected value is a range so the pixel count may jitter by a sample
    task automatic rd_reg(input logic [7:0] a, lo, hi);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        expq.push_back({lo, hi});
        @(posedge clk);
        rd <= 1'b0;
    endtask

    always @(posedge clk) begin
        logic [15:0] e;
        rd_d <= rd;
        if (rd_d) begin
            e = expq.pop_front();
            // Inside the window counts as the low bound, outside as itself
            chk((rdata >= e[15:8] && rdata <= e[7:0]) ? e[15:8] : rdata,
                e[15:8]);
        end
    end

    task automatic wait_irq(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            if (irq === 1'b1) return;
        end
        n_errors++;
        test_done();
    endtask

    function automatic logic [1:0] pexp(input logic [3:0] c, input logic f,
                                        input logic r);
        if (c[2]) return {1'b1, r};
        case (c[1:0])
            2'h0: return {1'b1, f};
            2'h1: return {1'b1, c[3]};
            default: return 2'h0;
        endcase
    endfunction

    task automatic set_pin(input logic [7:0] a, input logic [7:0] d);
        logic [3:0] c;
        seed = xs(seed);
        fout <= seed[5:0];
        rlev <= seed[13:8];
        wr_reg(a, d);
        if (a == csg_pkg::PIN0_SETUP) cfg0[psel] = d[3:0];
        else cfg12[psel] = d;
        repeat (3) @(posedge clk);
        @(negedge clk);
        for (int i = 0; i < 6; i++) begin
            c = (i % 3 == 0) ? cfg0[i/3] :
                (i % 3 == 1) ? cfg12[i/3][3:0] : cfg12[i/3][7:4];
            chk({6'h0, poe[i], poe[i] & pout[i]},
                {6'h0, pexp(c, fout[i], rlev[i])});
        end
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] e;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        rd_reg(csg_pkg::PIXEL_CLOCK_MEASURE, 8'h00, 8'h00);
        rd_reg(csg_pkg::PIN0_SETUP, {REV, 4'h0}, {REV, 4'h0});
        rd_reg(csg_pkg::PIN1_PIN2_SETUP, 8'h00, 8'h00);
        wr_reg(8'h50, 8'h5a);
        rd_reg(8'h50, 8'h00, 8'h00);
        for (int s = 0; s < 16; s++) begin
            {dual, aud, cdr} <= s[3:0];
            repeat (5) @(posedge clk);
            e = {3'h0, s[3], s[2], 2'h0, s[3] ? &s[1:0] : s[0]};
            rd_reg(csg_pkg::LINK_GENERAL_STATUS, e, e);
        end
        wr_reg(csg_pkg::IRQ_CLEAR, 8'h07);
        rd_reg(csg_pkg::IRQ_STATUS, 8'h00, 8'h00);
        {dual, aud, cdr} <= 4'h2;
        repeat (6) @(posedge clk);
        rd_reg(csg_pkg::IRQ_STATUS, 8'h06, 8'h06);
        wr_reg(csg_pkg::IRQ_CLEAR, 8'h07);
        for (int n = 0; n < 16; n++) begin
            set_pin(csg_pkg::PIN0_SETUP, 8'(n));
            rd_reg(csg_pkg::PIN0_SETUP, {REV, 4'(n)}, {REV, 4'(n)});
        end
        for (int n = 0; n < 8; n++) begin
            set_pin(csg_pkg::PIN1_PIN2_SETUP, seed[23:16]);
            rd_reg(csg_pkg::PIN1_PIN2_SETUP, cfg12[0], cfg12[0]);
        end
        wr_reg(csg_pkg::PORT_CONTROL, 8'h01);
        psel = 1'b1;
        set_pin(csg_pkg::PIN0_SETUP, 8'h0a);
        set_pin(csg_pkg::PIN0_SETUP, 8'h09);
        set_pin(csg_pkg::PIN1_PIN2_SETUP, 8'hd9);
        rd_reg(csg_pkg::PIN0_SETUP, {REV, 4'h9}, {REV, 4'h9});
        wr_reg(csg_pkg::PORT_CONTROL, 8'h00);
        psel = 1'b0;
        set_pin(csg_pkg::PIN1_PIN2_SETUP, 8'h9d);
        rd_reg(csg_pkg::PIN0_SETUP, {REV, cfg0[0]}, {REV, cfg0[0]});
        pin_in <= seed[29:24];
        repeat (4) @(posedge clk);
        rd_reg(csg_pkg::PIN_LEVELS, {2'h0, seed[29:24]}, {2'h0, seed[29:24]});
        wr_reg(csg_pkg::IRQ_ENABLE, 8'h01);
        wr_reg(csg_pkg::PIXEL_CLOCK_MEASURE, 8'd30);
        rd_reg(csg_pkg::PORT_CONTROL, 8'h80, 8'h80);
        wait_irq(2000);
        rd_reg(csg_pkg::PIXEL_CLOCK_MEASURE, 8'd9, 8'd11);
        rd_reg(csg_pkg::IRQ_STATUS, 8'h01, 8'h01);
        wr_reg(csg_pkg::IRQ_CLEAR, 8'h01);
        @(negedge clk);
        chk({7'h0, irq}, 8'h00);
        wr_reg(csg_pkg::IRQ_ENABLE, 8'h00);
        wr_reg(csg_pkg::PIXEL_CLOCK_MEASURE, 8'h00);
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk({7'h0, irq}, 8'h00);
        rd_reg(csg_pkg::IRQ_STATUS, 8'h01, 8'h01);
        rd_reg(csg_pkg::PIXEL_CLOCK_MEASURE, 8'h00, 8'h00);
        wr_reg(csg_pkg::IRQ_CLEAR, 8'h01);
        pix_half = 30;
        wr_reg(csg_pkg::IRQ_ENABLE, 8'h01);
        wr_reg(csg_pkg::PIXEL_CLOCK_MEASURE, 8'hff);
        wait_irq(1500);
        rd_reg(csg_pkg::PIXEL_CLOCK_MEASURE, 8'hff, 8'hff);
        repeat (4) @(posedge clk);
        test_done();
    end

endmodule // csg_regs_bench

`default_nettype wire
